/* sar_ctl_defines.svh */
// Constants of the converter control block and the contract list.
//
// Contract
// - Falling read strobe with chip and byte select low starts conversion.
// - Upper byte select high blocks read strobes from starting conversions.
// - Data drivers enabled only while read strobe and chip select are low.
// - Read strobe and byte select are ignored while chip select is high.
// - Busy output is low while a conversion runs, high when done.
// - Byte select low: twelve result bits in order on the twelve pins.
// - Byte select high: top nibble on top and low pins, middle pins low.
// - Clock output presents the inverse of the clock input.
// - Qualified strobes during a conversion neither restart nor abort it.
// - Start clears the approximation register; end loads result into latch.
// - First decision after second falling clock edge, then one per edge while the result buffer has room.
`ifndef SAR_CTL_DEFINES_SVH
`define SAR_CTL_DEFINES_SVH
`define RES_BITS 12
`define NIB_BITS 4
`define MSB_IDX 4'hb
`define FALL_BEFORE_MSB 2'h2
`define RESULT_RST 12'h000
`define TRIAL_MSB 12'h800
`define BUF_DEPTH 2
`endif

/* sar_ctl_pkg.sv */
// Types of the converter control block.
package sar_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } conv_state_e;
endpackage

/* result_buf.sv */
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/10ps
`include "sar_ctl_defines.svh"
module result_buf (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [11:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [11:0] out_data
);
  typedef struct packed {
    logic [1:0][11:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } buf_s;
  buf_s st_r;
  buf_s st_nxt;
  logic push;
  logic pop;
  assign in_ready = st_r.cnt != 2'h2;
  assign out_valid = st_r.cnt != 2'h0;
  assign out_data = st_r.mem[st_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  a_buf_count: assert property (@(posedge clock) disable iff (sys_rst)
    st_r.cnt <= 2'h2) else $error("Buffer count exceeds depth.");
endmodule

/* sar_ctl.sv */
// Conversion control, bit sequencing and parallel read-out of the converter.
`timescale 1ns/10ps
`include "sar_ctl_defines.svh"
module sar_ctl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic upper_byte_select,
  input wire logic conv_clk_in,
  output logic conv_clk_out,
  input wire logic comp_decision,
  output logic [11:0] dac_trial,
  output logic sample_hold,
  output logic busy_n,
  output logic [7:0] data_out_upper_pins,
  output logic [3:0] data_out_shared_pins,
  output logic data_oe,
  output logic result_valid,
  input wire logic result_ready,
  output logic [11:0] result_data
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] rd_s;
    logic [2:0] hb_s;
    logic [2:0] ck_s;
    logic cs_q;
    logic rd_q;
    logic hb_q;
    logic ck_q;
    sar_ctl_pkg::conv_state_e state;
    logic [1:0] falls;
    logic [3:0] bit_idx;
    logic [11:0] sar;
    logic [11:0] trial;
    logic [11:0] latch;
    logic busy_n;
    logic [11:0] dout;
    logic oe;
    logic push;
  } ctl_s;
  ctl_s st_r;
  ctl_s st_nxt;
  logic buf_ready;
  logic start;
  logic ck_fall;
  logic ck_edge;

  // Clock output is a plain inversion of the converter clock.
  assign conv_clk_out = ~conv_clk_in;

  // Read-out mapping for either byte mode.
  function automatic logic [11:0] map_out(input logic [11:0] r,
                                          input logic hb);
    if (hb) begin
      map_out = {r[11:8], 4'h0, r[11:8]};
    end else begin
      map_out = r;
    end
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[1:0], chip_sel_n};
    st_nxt.rd_s = {st_r.rd_s[1:0], read_n};
    st_nxt.hb_s = {st_r.hb_s[1:0], upper_byte_select};
    st_nxt.ck_s = {st_r.ck_s[1:0], conv_clk_in};
    // A change counts once the second and third stages agree.
    if (st_r.cs_s[1] == st_r.cs_s[2]) st_nxt.cs_q = st_r.cs_s[2];
    if (st_r.rd_s[1] == st_r.rd_s[2]) st_nxt.rd_q = st_r.rd_s[2];
    if (st_r.hb_s[1] == st_r.hb_s[2]) st_nxt.hb_q = st_r.hb_s[2];
    if (st_r.ck_s[1] == st_r.ck_s[2]) st_nxt.ck_q = st_r.ck_s[2];
    start = st_r.rd_q && !st_nxt.rd_q && !st_nxt.cs_q
            && !st_nxt.hb_q;
    ck_fall = st_r.ck_q && !st_nxt.ck_q;
    ck_edge = st_r.ck_q != st_nxt.ck_q;
    st_nxt.push = 1'b0;
    case (st_r.state)
      sar_ctl_pkg::ST_IDLE: begin
        if (start) begin
          st_nxt.state = sar_ctl_pkg::ST_WAIT;
          st_nxt.sar = `RESULT_RST;
          st_nxt.trial = `TRIAL_MSB;
          st_nxt.falls = 2'h0;
          st_nxt.busy_n = 1'b0;
        end
      end
      sar_ctl_pkg::ST_WAIT: begin
        if (ck_fall) begin
          st_nxt.falls = 2'(st_r.falls + 2'h1);
          if (2'(st_r.falls + 2'h1) == `FALL_BEFORE_MSB) begin
            st_nxt.sar[`MSB_IDX] = comp_decision;
            // The next trial keeps the decided bits and tests the next one.
            st_nxt.trial = st_nxt.sar;
            st_nxt.trial[4'(`MSB_IDX - 4'h1)] = 1'b1;
            st_nxt.bit_idx = 4'(`MSB_IDX - 4'h1);
            st_nxt.state = sar_ctl_pkg::ST_CONV;
          end
        end
      end
      sar_ctl_pkg::ST_CONV: begin
        // One decision per clock edge while the result buffer has room; strobes here are ignored.
        if (ck_edge && buf_ready) begin
          st_nxt.sar[st_r.bit_idx] = comp_decision;
          st_nxt.trial = st_nxt.sar;
          if (st_r.bit_idx == 4'h0) begin
            st_nxt.latch = st_nxt.sar;
            st_nxt.push = 1'b1;
            st_nxt.busy_n = 1'b1;
            st_nxt.state = sar_ctl_pkg::ST_IDLE;
          end else begin
            st_nxt.trial[4'(st_r.bit_idx - 4'h1)] = 1'b1;
            st_nxt.bit_idx = 4'(st_r.bit_idx - 4'h1);
          end
        end
      end
      default: st_nxt.state = sar_ctl_pkg::ST_IDLE;
    endcase
    st_nxt.oe = !st_nxt.cs_q && !st_nxt.rd_q;
    st_nxt.dout = map_out(st_nxt.latch, st_nxt.hb_q);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.cs_s <= 3'h7;
      st_r.rd_s <= 3'h7;
      st_r.ck_s <= 3'h0;
      st_r.cs_q <= 1'b1;
      st_r.rd_q <= 1'b1;
      st_r.state <= sar_ctl_pkg::ST_IDLE;
      st_r.busy_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dac_trial = st_r.trial;
  assign sample_hold = st_r.busy_n;
  assign busy_n = st_r.busy_n;
  assign data_oe = st_r.oe;
  assign data_out_upper_pins = st_r.dout[11:4];
  assign data_out_shared_pins = st_r.dout[3:0];

  result_buf u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(st_r.push),
    .in_ready(buf_ready),
    .in_data(st_r.latch),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_busy_state: assert property (@(posedge clock) disable iff (sys_rst)
    busy_n == (st_r.state == sar_ctl_pkg::ST_IDLE))
    else $error("Busy does not match conversion state.");
  a_oe_gate: assert property (@(posedge clock) disable iff (sys_rst)
    data_oe |-> (!st_r.cs_q && !st_r.rd_q))
    else $error("Output enabled without strobe and select.");
  a_no_start_hb: assert property (@(posedge clock) disable iff (sys_rst)
    (st_r.state == sar_ctl_pkg::ST_IDLE && st_nxt.hb_q) |=>
    st_r.state == sar_ctl_pkg::ST_IDLE)
    else $error("Conversion started with byte select high.");
  a_no_start_cs: assert property (@(posedge clock) disable iff (sys_rst)
    (st_r.state == sar_ctl_pkg::ST_IDLE && st_nxt.cs_q) |=>
    st_r.state == sar_ctl_pkg::ST_IDLE)
    else $error("Conversion started with chip select high.");
  a_start_go: assert property (@(posedge clock) disable iff (sys_rst)
    (st_r.state == sar_ctl_pkg::ST_IDLE && start) |=>
    (!busy_n && st_r.sar == `RESULT_RST))
    else $error("Qualified strobe did not start a conversion.");
  a_no_abort: assert property (@(posedge clock) disable iff (sys_rst)
    (st_r.state == sar_ctl_pkg::ST_CONV && !ck_edge) |=>
    st_r.state == sar_ctl_pkg::ST_CONV)
    else $error("Conversion left without a clock edge.");
  a_hb_map: assert property (@(posedge clock) disable iff (sys_rst)
    st_r.hb_q |-> (st_r.dout[7:4] == 4'h0
    && st_r.dout[3:0] == st_r.latch[11:8]))
    else $error("Upper byte mapping wrong.");
  a_full_map: assert property (@(posedge clock) disable iff (sys_rst)
    !st_r.hb_q |-> st_r.dout == st_r.latch)
    else $error("Full word mapping wrong.");
  a_clk_inv: assert property (@(posedge clock)
    conv_clk_out != conv_clk_in)
    else $error("Clock output not inverted.");
  a_end_latch: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(busy_n) |-> st_r.latch == st_r.sar)
    else $error("Result not latched at conversion end.");
endmodule

/* sar_front_model.sv */
// Comparator and sample-and-hold model facing the converter control.
`timescale 1ns/10ps
module sar_front_model (
  input wire logic clock,
  input wire logic sample_hold,
  input wire logic [11:0] level,
  input wire logic [11:0] dac_trial,
  output logic comp_decision
);
  logic [11:0] held_r;
  // The input is tracked while sampling and frozen for the conversion.
  always_ff @(posedge clock) begin
    if (sample_hold) begin
      held_r <= level;
    end
  end
  assign comp_decision = (held_r >= dac_trial);
endmodule

/* test_sar_ctl.sv */
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_sar_ctl;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_sel_n = 1'b1;
  logic read_n = 1'b1;
  logic upper_byte_select = 1'b0;
  logic conv_clk_in = 1'b0;
  logic result_ready = 1'b0;
  logic [11:0] level = 12'h000;
  logic conv_clk_out, comp_decision, sample_hold, busy_n, data_oe;
  logic result_valid;
  logic [11:0] dac_trial, result_data;
  logic [7:0] data_out_upper_pins;
  logic [3:0] data_out_shared_pins;
  int fails = 0;
  int checks_done = 0;
  int n;

  always #10 clock = ~clock;
  initial begin
    #33;
    forever #100 conv_clk_in = ~conv_clk_in;
  end

  sar_ctl dut (.clock(clock), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
    .read_n(read_n), .upper_byte_select(upper_byte_select),
    .conv_clk_in(conv_clk_in), .conv_clk_out(conv_clk_out),
    .comp_decision(comp_decision), .dac_trial(dac_trial),
    .sample_hold(sample_hold), .busy_n(busy_n),
    .data_out_upper_pins(data_out_upper_pins),
    .data_out_shared_pins(data_out_shared_pins), .data_oe(data_oe),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data));
  sar_front_model far_end (.clock(clock), .sample_hold(sample_hold),
    .level(level), .dac_trial(dac_trial), .comp_decision(comp_decision));

  // A strobe is followed by a 240 ns gap before anything else starts.
  task automatic rd(input logic hb, input logic [11:0] e);
    logic [11:0] exp_w;
    exp_w = hb ? {e[11:8], 4'h0, e[11:8]} : e;
    @(posedge conv_clk_in);
    repeat (3) @(posedge clock);
    chip_sel_n <= 1'b0;
    upper_byte_select <= hb;
    read_n <= 1'b0;
    repeat (8) @(negedge clock);
    `CHK(data_oe, 1'b1)
    `CHK({data_out_upper_pins, data_out_shared_pins}, exp_w)
    @(posedge clock);
    read_n <= 1'b1;
    chip_sel_n <= 1'b1;
    repeat (12) @(negedge clock);
    `CHK(data_oe, 1'b0)
  endtask

  task automatic conv(input logic [11:0] v, input logic [11:0] p, bit stall);
    @(posedge clock);
    level <= v;
    rd(1'b0, p);
    `CHK(busy_n, 1'b0)
    rd(1'b0, p);
    `CHK(busy_n, 1'b0)
    if (stall) begin
      repeat (200) @(negedge clock);
      `CHK(busy_n, 1'b0)
      return;
    end
    for (n = 0; busy_n !== 1'b1 && n < 400; n++) @(negedge clock);
    `CHK(40 + n <= 136, 1'b1)
    repeat (55) @(negedge clock);
  endtask

  task automatic pop(input logic [11:0] e);
    @(negedge clock);
    `CHK(result_valid, 1'b1)
    `CHK(result_data, e)
    @(posedge clock);
    result_ready <= 1'b1;
    @(posedge clock);
    result_ready <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The tests need about 720 cycles; the watchdog allows far more.
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(negedge clock);
    `CHK(busy_n, 1'b1)
    `CHK(data_oe, 1'b0)
    for (int i = 0; i < 4; i++) begin
      repeat (7) @(negedge clock);
      `CHK(conv_clk_out, ~conv_clk_in)
    end
    $display("test idle done");
    conv(12'ha5c, 12'h000, 1'b0);
    `CHK(result_valid, 1'b1)
    conv(12'h3c7, 12'ha5c, 1'b0);
    conv(12'h801, 12'h3c7, 1'b1);
    pop(12'ha5c);
    for (n = 0; busy_n !== 1'b1 && n < 80; n++) @(negedge clock);
    `CHK(busy_n, 1'b1)
    pop(12'h3c7);
    pop(12'h801);
    @(negedge clock);
    `CHK(result_valid, 1'b0)
    $display("test conversions done");
    repeat (55) @(negedge clock);
    rd(1'b1, 12'h801);
    `CHK(busy_n, 1'b1)
    @(posedge clock);
    upper_byte_select <= 1'b0;
    read_n <= 1'b0;
    repeat (8) @(negedge clock);
    `CHK(data_oe, 1'b0)
    @(posedge clock);
    read_n <= 1'b1;
    repeat (20) @(negedge clock);
    `CHK(busy_n, 1'b1)
    $display("test refusals done");
    wrap_up();
  end
endmodule
